// ===== hw/tpu_timer.sv
// tpu_timer: 16-bit timer counter with buffered channel value registers
// assumes: byte register port, read data one cycle after read strobe,
// counting clocks no faster than the bus clock, external one below 1/4
`timescale 1ns/1ns
module tpu_timer import tpu_pkg::*; #(
  parameter int NCH = 2
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [7:0] o_rdata,
  input wire logic i_debug,
  input wire logic i_fixed_clk,
  input wire logic i_ext_clk,
  input wire logic [NCH-1:0] i_ch_pin,
  output logic [NCH-1:0] o_ch_out,
  output logic [NCH-1:0] o_ch_oe,
  output logic o_ovf_irq,
  output logic [NCH-1:0] o_ch_irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ovf, ovf_arm, ovf_ie, cas, down;
    logic [1:0] clks;
    logic [2:0] ps;
    logic [PSC_W-1:0] psc;
    logic [15:0] cnt, modv, cnt_buf;
    logic cnt_lat, cnt_hi_first;
    logic [NCH-1:0] ev, ev_arm, ie, mb, ma, elb, ela;
    logic [NCH-1:0] wh, wl, wpend, rlat, rhi, out, pin_q;
    logic [NCH-1:0][15:0] cval, wbuf, rbuf;
    logic [7:0] rdata;
  } tpu_state_s;

  tpu_state_s s;
  tpu_state_s n;
  logic [1:0] rst_q;
  logic rst_n;
  logic [1:0] clk_rise;
  logic [15:0] tc;
  logic src, psc_end, tick, ovf_evt, pwm_load;
  logic [NCH-1:0] sel_sc, sel_vh, sel_vl, cap, cmp, edge_aligned_pwm, cap_hit, match;

  // ---------------------------------------------------------------
  // reset release and clock synchronisers
  // ---------------------------------------------------------------
  // reset released through two flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  tpu_edge_sync #(.WIDTH(2)) u_sync (
    .i_clk(i_clk),
    .i_rstn(rst_n),
    .i_d({i_ext_clk, i_fixed_clk}),
    .o_rise(clk_rise)
  );

  // ---------------------------------------------------------------
  // per-channel decode
  // ---------------------------------------------------------------
  // mode decode, center select overrides
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_dec
      localparam logic [7:0] BASE = 8'(CH_BASE + CH_STRIDE * g);
      assign sel_sc[g] = (i_addr == BASE);
      assign sel_vh[g] = (i_addr == 8'(BASE + CH_VH_OFS));
      assign sel_vl[g] = (i_addr == 8'(BASE + CH_VL_OFS));
      assign cap[g] = !s.cas && !s.mb[g] && !s.ma[g];
      assign cmp[g] = !s.cas && !s.mb[g] && s.ma[g];
      assign edge_aligned_pwm[g] = !s.cas && s.mb[g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // counter clocking
  // ---------------------------------------------------------------
  assign tc = (s.modv == CNT_ZERO) ? CNT_FULL : s.modv;

  always_comb begin
    unique case (s.clks)
      CLK_BUS: src = 1'b1;
      CLK_FIX: src = clk_rise[0];
      CLK_EXT: src = clk_rise[1];
      CLK_OFF: src = 1'b0;
    endcase
  end
  assign psc_end = (s.psc == PSC_W'((8'h01 << s.ps) - 8'h01));
  // counter frozen while debug mode holds
  assign tick = src && psc_end && !i_debug;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n = s;
    n.rdata = BYTE_ZERO;
    ovf_evt = 1'b0;
    pwm_load = 1'b0;
    if (src && !i_debug) begin
      n.psc = psc_end ? '0 : PSC_W'(s.psc + 1'b1);
    end
    // counter step
    if (tick) begin
      if (!s.cas) begin
        if (s.cnt == tc) begin
          n.cnt = CNT_ZERO;
          ovf_evt = 1'b1;
        end else begin
          n.cnt = s.cnt + CNT_ONE;
        end
      end else if (!s.down) begin
        if (s.cnt == tc) begin
          n.down = 1'b1;
          n.cnt = s.cnt - CNT_ONE;
          ovf_evt = 1'b1;
        end else begin
          n.cnt = s.cnt + CNT_ONE;
        end
      end else if (s.cnt == CNT_ZERO) begin
        n.down = 1'b0;
        n.cnt = CNT_ONE;
      end else begin
        n.cnt = s.cnt - CNT_ONE;
      end
      pwm_load = !s.down && (s.cnt != tc) && (n.cnt == tc);
    end

    // timer status/control access
    if (i_re && i_addr == TSC_ADDR) begin
      n.rdata = {s.ovf, s.ovf_ie, s.cas, s.clks, s.ps};
      n.ovf_arm = s.ovf;
    end
    if (i_we && i_addr == TSC_ADDR) begin
      n.ovf_ie = i_wdata[IE_BIT];
      n.cas = i_wdata[CAS_BIT];
      n.clks = i_wdata[CLKS_LSB +: 2];
      n.ps = i_wdata[PS_LSB +: 3];
      if (s.ovf_arm && !i_wdata[FLAG_BIT]) begin
        n.ovf = 1'b0;
        n.ovf_arm = 1'b0;
      end
    end
    // set wins over a clear in the same cycle
    if (ovf_evt) begin
      n.ovf = 1'b1;
    end

    // counter read with coherent byte pair
    if (i_re && (i_addr == CNTH_ADDR || i_addr == CNTL_ADDR)) begin
      if (s.cnt_lat) begin
        n.rdata = (i_addr == CNTH_ADDR) ? s.cnt_buf[15:8] : s.cnt_buf[7:0];
        if ((i_addr == CNTH_ADDR) != s.cnt_hi_first) begin
          n.cnt_lat = 1'b0;
        end
      end else begin
        n.rdata = (i_addr == CNTH_ADDR) ? s.cnt[15:8] : s.cnt[7:0];
        n.cnt_buf = s.cnt;
        n.cnt_lat = 1'b1;
        n.cnt_hi_first = (i_addr == CNTH_ADDR);
      end
    end
    // counter write clears count and latch
    if (i_we && (i_addr == CNTH_ADDR || i_addr == CNTL_ADDR)) begin
      n.cnt = CNT_ZERO;
      n.psc = '0;
      n.down = 1'b0;
      n.cnt_lat = 1'b0;
    end
    // modulus bytes
    if (i_re && i_addr == MODH_ADDR) begin
      n.rdata = s.modv[15:8];
    end
    if (i_re && i_addr == MODL_ADDR) begin
      n.rdata = s.modv[7:0];
    end
    if (i_we && i_addr == MODH_ADDR) begin
      n.modv[15:8] = i_wdata;
    end
    if (i_we && i_addr == MODL_ADDR) begin
      n.modv[7:0] = i_wdata;
    end

    // channels
    for (int i = 0; i < NCH; i++) begin
      n.pin_q[i] = i_ch_pin[i];
      cap_hit[i] = cap[i] && ((s.ela[i] && i_ch_pin[i] && !s.pin_q[i])
                   || (s.elb[i] && !i_ch_pin[i] && s.pin_q[i]));
      match[i] = tick && !cap[i] && (n.cnt == s.cval[i]);
      if (cap_hit[i]) begin
        n.cval[i] = s.cnt;
      end
      if (cmp[i] && match[i]) begin
        unique case ({s.elb[i], s.ela[i]})
          2'h1: n.out[i] = !s.out[i];
          2'h2: n.out[i] = 1'b0;
          2'h3: n.out[i] = 1'b1;
          2'h0: n.out[i] = s.out[i];
        endcase
      end
      // pwm edges, polarity from edge_level_a
      if (edge_aligned_pwm[i] && ovf_evt) begin
        n.out[i] = !s.ela[i];
      end
      if ((edge_aligned_pwm[i] || (s.cas && !n.down)) && match[i]) begin
        n.out[i] = s.ela[i];
      end
      if (s.cas && n.down && match[i]) begin
        n.out[i] = !s.ela[i];
      end

      if (s.wpend[i] && cmp[i] && tick) begin
        n.cval[i] = s.wbuf[i];
        n.wpend[i] = 1'b0;
      end
      if (s.wpend[i] && (edge_aligned_pwm[i] || s.cas) && pwm_load) begin
        n.cval[i] = s.wbuf[i];
        n.wpend[i] = 1'b0;
      end

      if (i_we && (sel_vh[i] || sel_vl[i]) && !cap[i]) begin
        if (i_debug) begin
          if (sel_vh[i]) begin
            n.cval[i][15:8] = i_wdata;
          end else begin
            n.cval[i][7:0] = i_wdata;
          end
        end else begin
          if (sel_vh[i]) begin
            n.wbuf[i][15:8] = i_wdata;
            n.wh[i] = 1'b1;
          end else begin
            n.wbuf[i][7:0] = i_wdata;
            n.wl[i] = 1'b1;
          end
          if (n.wh[i] && n.wl[i]) begin
            n.wh[i] = 1'b0;
            n.wl[i] = 1'b0;
            if (s.clks == CLK_OFF) begin
              n.cval[i] = n.wbuf[i];
              n.wpend[i] = 1'b0;
            end else begin
              n.wpend[i] = 1'b1;
            end
          end
        end
      end

      // value byte reads, live by default
      if (i_re && (sel_vh[i] || sel_vl[i])) begin
        n.rdata = sel_vh[i] ? s.cval[i][15:8] : s.cval[i][7:0];
        if (cap[i] && !i_debug) begin
          if (s.rlat[i]) begin
            n.rdata = sel_vh[i] ? s.rbuf[i][15:8] : s.rbuf[i][7:0];
            if (sel_vh[i] != s.rhi[i]) begin
              n.rlat[i] = 1'b0;
            end
          end else begin
            n.rbuf[i] = s.cval[i];
            n.rlat[i] = 1'b1;
            n.rhi[i] = sel_vh[i];
          end
        end
      end

      // channel status/control
      if (i_re && sel_sc[i]) begin
        n.rdata = {s.ev[i], s.ie[i], s.mb[i], s.ma[i], s.elb[i], s.ela[i], 2'h0};
        n.ev_arm[i] = s.ev[i];
      end
      if (i_we && sel_sc[i]) begin
        n.ie[i] = i_wdata[IE_BIT];
        n.mb[i] = i_wdata[MB_BIT];
        n.ma[i] = i_wdata[MA_BIT];
        n.elb[i] = i_wdata[ELB_BIT];
        n.ela[i] = i_wdata[ELA_BIT];
        if (s.ev_arm[i] && !i_wdata[FLAG_BIT]) begin
          n.ev[i] = 1'b0;
          n.ev_arm[i] = 1'b0;
        end
        n.rlat[i] = 1'b0;
        n.wh[i] = 1'b0;
        n.wl[i] = 1'b0;
      end
      // match flags even with output off
      if (cap_hit[i] || match[i]) begin
        n.ev[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_rdata = s.rdata;
  assign o_ovf_irq = s.ovf && s.ovf_ie;
  assign o_ch_irq = s.ev & s.ie;
  assign o_ch_out = s.out;
  // pin released when edge/level is 00
  assign o_ch_oe = (s.elb | s.ela) & ~cap;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  sequence low_byte_closes_pair;
    s.wh[0] && !s.wl[0] && i_we && sel_vl[0] && !i_debug && !cap[0];
  endsequence

  ovf_irq_raise_a: assert property (
    ovf_evt && s.ovf_ie && !(i_we && i_addr == TSC_ADDR) |=> o_ovf_irq)
    else $error("overflow set with enable but no irq");

  cap_write_ignored_a: assert property (
    i_we && (sel_vh[0] || sel_vl[0]) && cap[0] && !cap_hit[0] |=> $stable(s.cval[0]))
    else $error("capture value changed by write");

  sc_unlatch_a: assert property (
    i_we && sel_sc[0] |=> !s.rlat[0] && !s.wh[0] && !s.wl[0])
    else $error("control write left a latch set");

  dbg_latch_frozen_a: assert property (
    i_debug && !(i_we && sel_sc[0]) |=> s.rlat[0] == $past(s.rlat[0]))
    else $error("read latch moved in debug");

  dbg_live_read_a: assert property (
    i_re && i_debug && sel_vl[0] |=> o_rdata == $past(s.cval[0][7:0]))
    else $error("debug read not live value");

  imm_load_a: assert property (
    low_byte_closes_pair ##0 (s.clks == CLK_OFF)
    |=> s.cval[0] == {$past(s.wbuf[0][15:8]), $past(i_wdata)})
    else $error("pair not loaded at second byte");

  up_wrap_a: assert property (
    tick && !s.cas && s.cnt == tc && !(i_we && i_addr == CNTL_ADDR) |=> s.ovf && s.cnt == CNT_ZERO)
    else $error("no overflow at wrap");

  cnt_clear_a: assert property (
    i_we && (i_addr == CNTH_ADDR || i_addr == CNTL_ADDR) |=> s.cnt == CNT_ZERO && !s.cnt_lat)
    else $error("counter write did not clear");

  center_turn_a: assert property (
    tick && s.cas && !s.down && s.cnt == tc && !i_we |=> s.down && s.ovf)
    else $error("no turn at terminal");
endmodule : tpu_timer

// ===== inc/tpu_pkg.sv
// tpu_pkg: register map, field layout and constants of the timer unit
// assumes: byte-wide register port, one bus clock
package tpu_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] TSC_ADDR = 8'h00;
  localparam logic [7:0] CNTH_ADDR = 8'h01;
  localparam logic [7:0] CNTL_ADDR = 8'h02;
  localparam logic [7:0] MODH_ADDR = 8'h03;
  localparam logic [7:0] MODL_ADDR = 8'h04;
  localparam logic [7:0] CH_BASE = 8'h05;
  localparam logic [7:0] CH_STRIDE = 8'h03;
  localparam logic [7:0] CH_VH_OFS = 8'h01;
  localparam logic [7:0] CH_VL_OFS = 8'h02;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FLAG_BIT = 7;
  localparam int IE_BIT = 6;
  localparam int CAS_BIT = 5;
  localparam int CLKS_LSB = 3;
  localparam int PS_LSB = 0;
  localparam int MB_BIT = 5;
  localparam int MA_BIT = 4;
  localparam int ELB_BIT = 3;
  localparam int ELA_BIT = 2;
  // ---------------------------------------------------------------
  // encodings and values
  // ---------------------------------------------------------------
  localparam logic [1:0] CLK_OFF = 2'h0;
  localparam logic [1:0] CLK_BUS = 2'h1;
  localparam logic [1:0] CLK_FIX = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam int PSC_W = 7;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_FULL = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage : tpu_pkg

// ===== hw/tpu_edge_sync.sv
// tpu_edge_sync: two-flop synchroniser with rising-edge pulse out
// assumes: inputs asynchronous to i_clk, reset already synchronised
`timescale 1ns/1ns
module tpu_edge_sync import tpu_pkg::*; #(
  parameter int WIDTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_rise
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;
  } tpu_sync_s;

  tpu_sync_s s;
  tpu_sync_s next_s;

  // shift chain; meta is read only by sync
  always_comb begin
    next_s.meta = i_d;
    next_s.sync = s.meta;
    next_s.last = s.sync;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // one pulse per rising edge of the synchronised level
  assign o_rise = s.sync & ~s.last;
endmodule : tpu_edge_sync

// ===== sim/tpu_timer_tb.sv
// tpu_timer_tb: self-checking bench for the timer unit
// assumes: tpu_pkg compiled first, 20 MHz bus clock
`timescale 1ns/1ns
module tpu_timer_tb import tpu_pkg::*;;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] exp;
  } tpu_note_s;
  localparam logic [7:0] CSC0 = CH_BASE;
  localparam logic [7:0] VH0 = CH_BASE + CH_VH_OFS;
  localparam logic [7:0] VL0 = CH_BASE + CH_VL_OFS;
  logic i_clk;
  logic i_rstn;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic i_we;
  logic i_re;
  logic i_debug;
  logic i_fixed_clk;
  logic i_ext_clk;
  logic [1:0] i_ch_pin;
  logic [7:0] o_rdata;
  logic [1:0] o_ch_out;
  logic [1:0] o_ch_oe;
  logic o_ovf_irq;
  logic [1:0] o_ch_irq;
  logic re_q;
  logic [15:0] rv;
  int failures;
  int check_count;
  int seed;
  tpu_note_s notes[$];
  tpu_note_s cur;

  tpu_timer #(.NCH(2)) u_tpu_timer (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .i_debug(i_debug),
    .i_fixed_clk(i_fixed_clk), .i_ext_clk(i_ext_clk), .i_ch_pin(i_ch_pin),
    .o_ch_out(o_ch_out), .o_ch_oe(o_ch_oe), .o_ovf_irq(o_ovf_irq), .o_ch_irq(o_ch_irq)
  );

  // ---------------------------------------------------------------
  // clock, checking and closing
  // ---------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // read data stands the cycle after the strobe
  always @(posedge i_clk) re_q <= i_re;
  always @(negedge i_clk) begin
    if (re_q === 1'b1) begin
      if (notes.size() == 0) begin
        failures++;
        $display("FAIL rdata expected none seen %h", o_rdata);
      end else begin
        cur = notes.pop_front();
        check($sformatf("rdata at %h", cur.addr), cur.exp, o_rdata);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    $display("FAIL timeout expected finish seen hang");
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // bus and stimulus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_we <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    notes.push_back('{a, e});
    i_re <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_re <= 1'b0;
  endtask : rd

  // slow counting clocks
  // fixed and external pins pulse together, one eighth of the bus rate
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_clk);
      i_fixed_clk <= 1'b1;
      i_ext_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_fixed_clk <= 1'b0;
      i_ext_clk <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
    repeat (6) @(posedge i_clk);
  endtask : tick

  // rising edge on channel 0 pin
  task automatic capture();
    @(posedge i_clk);
    i_ch_pin <= 2'b01;
    repeat (4) @(posedge i_clk);
    i_ch_pin <= 2'b00;
    repeat (6) @(posedge i_clk);
  endtask : capture

  task automatic set_debug(input logic v);
    @(posedge i_clk);
    i_debug <= v;
  endtask : set_debug

  task automatic check_irq(input logic e);
    @(negedge i_clk);
    check("ovf_irq", {7'h00, e}, {7'h00, o_ovf_irq});
  endtask : check_irq

  // channel pin and irq outputs at the next falling edge
  task automatic check_pins(input logic [1:0] oe, input logic [1:0] out, input logic [1:0] irq);
    @(negedge i_clk);
    check("ch_oe", {6'h00, oe}, {6'h00, o_ch_oe});
    check("ch_out", {6'h00, out}, {6'h00, o_ch_out});
    check("ch_irq", {6'h00, irq}, {6'h00, o_ch_irq});
  endtask : check_pins

  task automatic done(input string t);
    $display("test %s done", t);
  endtask : done

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int k;
    i_rstn = 1'b0;
    i_addr = BYTE_ZERO;
    i_wdata = BYTE_ZERO;
    i_we = 1'b0;
    i_re = 1'b0;
    i_debug = 1'b0;
    i_fixed_clk = 1'b0;
    i_ext_clk = 1'b0;
    i_ch_pin = 2'b00;
    failures = 0;
    check_count = 0;
    seed = 86127;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk);
    // value bytes of both channels after reset
    for (k = 0; k < 2; k++) begin
      rd(8'(CH_BASE + CH_STRIDE * k + CH_VH_OFS), 8'h00);
      rd(8'(CH_BASE + CH_STRIDE * k + CH_VL_OFS), 8'h00);
    end
    done("reset");
    // capture coherency, counter 0x0102 then 0x0105
    wr(CSC0, 8'h04);
    wr(TSC_ADDR, 8'h10);
    wr(CNTL_ADDR, 8'h00);
    tick(258);
    capture();
    rd(VH0, 8'h01);
    tick(3);
    capture();
    rd(VL0, 8'h02);
    rd(VH0, 8'h01);
    rd(VL0, 8'h05);
    done("capture");
    // debug freezes latch and reads live value
    rd(VH0, 8'h01);
    tick(1);
    capture();
    set_debug(1'b1);
    rd(VL0, 8'h06);
    rd(VH0, 8'h01);
    set_debug(1'b0);
    rd(VL0, 8'h05);
    rd(VH0, 8'h01);
    tick(1);
    capture();
    wr(CSC0, 8'h04);
    rd(VL0, 8'h07);
    rd(VH0, 8'h01);
    wr(VH0, 8'h99);
    wr(VL0, 8'h99);
    rd(VH0, 8'h01);
    rd(VL0, 8'h07);
    rd(CNTH_ADDR, 8'h01);
    wr(CNTH_ADDR, 8'hAA);
    rd(CNTL_ADDR, 8'h00);
    rd(CNTH_ADDR, 8'h00);
    done("debug_read");
    // compare load on next counter step, then stop
    wr(CSC0, 8'h50);
    check_pins(2'b00, 2'b00, 2'b01);
    wr(VH0, 8'h12);
    wr(VL0, 8'h34);
    rd(VH0, 8'h01);
    rd(VL0, 8'h07);
    tick(1);
    rd(VH0, 8'h12);
    rd(VL0, 8'h34);
    wr(TSC_ADDR, 8'h00);
    tick(2);
    rd(CNTH_ADDR, 8'h00);
    rd(CNTL_ADDR, 8'h01);
    done("compare");
    // clock off: load at second byte, low byte first
    rv = 16'($random(seed));
    wr(VL0, rv[7:0]);
    rd(VH0, 8'h12);
    wr(VH0, rv[15:8]);
    rd(VH0, rv[15:8]);
    rd(VL0, rv[7:0]);
    // debug writes bypass, half pair kept
    wr(VH0, 8'hA1);
    set_debug(1'b1);
    wr(VL0, 8'hB2);
    rd(VH0, rv[15:8]);
    rd(VL0, 8'hB2);
    set_debug(1'b0);
    wr(VL0, 8'hC3);
    rd(VH0, 8'hA1);
    rd(VL0, 8'hC3);
    done("clock_off");
    // edge pwm, modulus 4, load at 3 to 4
    wr(MODH_ADDR, 8'h00);
    wr(MODL_ADDR, 8'h04);
    wr(CSC0, 8'h28);
    wr(TSC_ADDR, 8'h50);
    wr(CNTL_ADDR, 8'h00);
    wr(VH0, 8'h00);
    wr(VL0, 8'h03);
    tick(3);
    rd(VL0, 8'hC3);
    check_pins(2'b01, 2'b00, 2'b00);
    tick(1);
    rd(VH0, 8'h00);
    rd(VL0, 8'h03);
    rd(TSC_ADDR, 8'h50);
    check_irq(1'b0);
    tick(1);
    rd(TSC_ADDR, 8'hD0);
    rd(CNTH_ADDR, 8'h00);
    rd(CNTL_ADDR, 8'h00);
    check_pins(2'b01, 2'b01, 2'b00);
    check_irq(1'b1);
    wr(TSC_ADDR, 8'h90);
    check_irq(1'b0);
    rd(TSC_ADDR, 8'h90);
    wr(TSC_ADDR, 8'hD0);
    check_irq(1'b1);
    rd(TSC_ADDR, 8'hD0);
    wr(TSC_ADDR, 8'h10);
    check_irq(1'b0);
    rd(TSC_ADDR, 8'h10);
    done("edge_pwm");
    // center mode, modulus 2: 0 1 2 1 0 1
    wr(MODL_ADDR, 8'h02);
    wr(TSC_ADDR, 8'h30);
    wr(CNTL_ADDR, 8'h00);
    tick(2);
    rd(TSC_ADDR, 8'h30);
    tick(1);
    rd(TSC_ADDR, 8'hB0);
    rd(CNTH_ADDR, 8'h00);
    rd(CNTL_ADDR, 8'h01);
    tick(2);
    rd(CNTH_ADDR, 8'h00);
    rd(CNTL_ADDR, 8'h01);
    done("center");
    // external clock divided by 2, then bus clock divided by 4
    wr(MODL_ADDR, 8'h00);
    wr(TSC_ADDR, 8'h19);
    wr(CNTL_ADDR, 8'h00);
    tick(4);
    rd(CNTL_ADDR, 8'h02);
    rd(CNTH_ADDR, 8'h00);
    wr(CNTL_ADDR, 8'h00);
    wr(TSC_ADDR, 8'h0A);
    repeat (17) @(posedge i_clk);
    wr(TSC_ADDR, 8'h02);
    rd(CNTL_ADDR, 8'h04);
    rd(CNTH_ADDR, 8'h00);
    done("clocks");
    k = 0;
    while (notes.size() != 0 && k < 20) begin
      @(posedge i_clk);
      k++;
    end
    if (notes.size() != 0) begin
      failures++;
      $display("FAIL pending reads expected 0 seen %0d", notes.size());
    end
    report_and_stop();
  end
endmodule : tpu_timer_tb
